// File: common/sra_pkg.sv
// Shared constants and types of the serial register access front end
package sra_pkg;
    // Register addresses carried in the command byte
    localparam logic [5:0] ADDR_CMD   = 6'h00;  // Command byte
    localparam logic [5:0] ADDR_PORT  = 6'h01;  // Digital port control
    localparam logic [5:0] ADDR_REV   = 6'h02;  // Revision
    localparam logic [5:0] ADDR_TEST  = 6'h03;  // Factory test
    localparam logic [5:0] ADDR_STAT  = 6'h04;  // Converter ready flags
    localparam logic [5:0] ADDR_SUM   = 6'h05;  // Integrity sum
    localparam logic [5:0] ADDR_ZERO  = 6'h06;  // Converter zero coefficient
    localparam logic [5:0] ADDR_DATA0 = 6'h08;  // Channel 0 result
    localparam logic [5:0] ADDR_DATA1 = 6'h0A;  // Channel 1 result
    localparam logic [5:0] ADDR_MODE0 = 6'h38;  // Mode, channel 0
    localparam logic [5:0] ADDR_MODE1 = 6'h3A;  // Mode, channel 1
    // Command byte fields
    localparam int CMD_RW_BIT    = 6;           // 1 = read
    localparam int ADDR_CHAN_BIT = 1;           // Channel select in address
    // Port control fields
    localparam int PORT_LVL0_BIT  = 7;
    localparam int PORT_LVL1_BIT  = 6;
    localparam int PORT_DIR0_BIT  = 5;
    localparam int PORT_DIR1_BIT  = 4;
    localparam int PORT_READY_PIN_FUNCTION_BIT = 3;
    localparam int PORT_SYNC_BIT  = 0;
    // Ready flag positions in the status byte
    localparam int STAT_CHAN_ZERO_DONE_FLAG_BIT = 0;
    localparam int STAT_CHAN_ONE_DONE_FLAG_BIT = 2;
    // Mode register fields
    localparam int MODE_MD_MSB   = 7;
    localparam int MODE_MD_LSB   = 5;
    localparam int MODE_WIDE_BIT = 1;           // 1 = 24-bit results
    localparam logic [2:0] MD_IDLE = 3'h0;
    // Reset values
    localparam logic [23:0] ZERO_RESET = 24'h80_0000;
    localparam logic [23:0] TEST_RESET = 24'h00_0000;
    localparam logic [15:0] SUM_RESET  = 16'h0000;
    localparam logic [7:0]  MODE_RESET = 8'h00;
    localparam logic [1:0]  DIR_RESET  = 2'h3;  // Both pins inputs
    // Transfer lengths in serial clocks
    localparam logic [4:0] LEN_8  = 5'h08;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] LEN_24 = 5'h18;
    // Ones needed to reset the interface
    localparam logic [5:0] ONES_RESET = 6'h20;
    // Interface states
    typedef enum logic [2:0] {
        ST_CMD   = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } sra_state_type;
endpackage : sra_pkg

// File: rtl/sra_top.sv
// Serial register access front end of a two-channel converter
//
// Summary of operation
// - Each transaction opens with a command byte
// - Command bit 6 picks read or write
// - Command bits 5..0 address; bit 7 zero
// - Address bit 1 selects channel and mode
// - After transfer, next byte is a command
// - 32 ones with select low resets all
// - Port bits 7,6 drive or read pins
// - Direction bits 5,4: one means input
// - Ready pin: any channel or all enabled
// - Port bit 0 enables sync pin
// - Revision register: revision and generic code
// - Finished conversion sets channel ready flag
// - Reading channel data clears its flag
// - Unread result update clears the flag
// - Mode write clears all ready flags
// - Calibration holds flags low, then sets
// - Flag bits 0 and 2, others zero
// - Zero coefficient resets to 800000h, auto-loaded
// - Zero coefficient writable only when idle
`timescale 1ns/1ps
module sra_top #(
    parameter logic [3:0] REV_CODE     = 4'h1,  // Arbitrary value
    parameter logic [3:0] GENERIC_CODE = 4'h9   // Arbitrary value
) (
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        DIN,
    output logic             DOUT,
    output logic             DOUT_OE_N,
    input  wire logic        PORT_PIN_ZERO_IN,
    output logic             PORT_PIN_ZERO_OUT,
    output logic             PORT_PIN_ZERO_OE_N,
    input  wire logic        PORT_PIN_ONE_IN,
    output logic             PORT_PIN_ONE_OUT,
    output logic             PORT_PIN_ONE_OE_N,
    output logic             RDY_N,
    output logic             SYNC_EN,
    input  wire logic [1:0]  CHAN_ENABLE,
    input  wire logic [1:0]  CONV_UPDATE,
    input  wire logic [1:0]  CONV_DONE,
    input  wire logic [23:0] CONV_DATA0,
    input  wire logic [23:0] CONV_DATA1,
    input  wire logic        CAL_BUSY,
    input  wire logic        CAL_DONE,
    input  wire logic        ZERO_CAL_LOAD,
    input  wire logic [23:0] ZERO_CAL_VALUE,
    output logic [23:0]      ZERO_COEF,
    output logic [7:0]       MODE_VALUE,
    output logic             MODE_CHANNEL,
    output logic             MODE_WRITE,
    output logic             SOFT_RESET
);

    // Transfer length of a register, in serial clocks
    function automatic logic [4:0] reg_len(input logic [5:0] addr, input logic wide);
        case (addr)
            sra_pkg::ADDR_TEST, sra_pkg::ADDR_ZERO: reg_len = sra_pkg::LEN_24;
            sra_pkg::ADDR_SUM:                      reg_len = sra_pkg::LEN_16;
            sra_pkg::ADDR_DATA0, sra_pkg::ADDR_DATA1:
                reg_len = wide ? sra_pkg::LEN_24 : sra_pkg::LEN_16;
            default:                                reg_len = sra_pkg::LEN_8;
        endcase
    endfunction : reg_len

    // Two-stage synchronisers for pins
    logic [4:0] pin_s1_r;                // First stage, read only by second
    logic [4:0] pin_s2_r;                // Synchronised pins
    logic       sclk_d_r;                // Previous synchronised serial clock
    logic       sclk_s, cs_low, din_s;   // Synchronised link signals
    logic [1:0] port_pin_s;              // Synchronised port pins
    logic       sclk_rise, sclk_fall;    // Serial clock edges

    // Capture pins, then delay clock for edge finding
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pin_s1_r <= 5'h03;
            pin_s2_r <= 5'h03;
            sclk_d_r <= 1'b1;
        end else begin
            pin_s1_r <= {PORT_PIN_ONE_IN, PORT_PIN_ZERO_IN, DIN, CS_N, SCLK};
            pin_s2_r <= pin_s1_r;
            sclk_d_r <= pin_s2_r[0];
        end
    end

    assign sclk_s     = pin_s2_r[0];
    assign cs_low     = !pin_s2_r[1];
    assign din_s      = pin_s2_r[2];
    assign port_pin_s = pin_s2_r[4:3];
    assign sclk_rise  = cs_low && sclk_s && !sclk_d_r;
    assign sclk_fall  = cs_low && !sclk_s && sclk_d_r;

    // Interface and register state
    sra_pkg::sra_state_type state_r, state_nxt;  // Interface state
    logic [4:0]  cnt_r, cnt_nxt;                 // Bits done this phase
    logic [4:0]  len_r, len_nxt;                 // Length of data phase
    logic [23:0] sh_r, sh_nxt;                   // Shift register
    logic [5:0]  addr_r, addr_nxt;               // Target of data phase
    logic [5:0]  ones_r, ones_nxt;               // Consecutive ones seen
    logic [1:0]  lvl_r, lvl_nxt;                 // Port output levels
    logic [1:0]  dir_r, dir_nxt;                 // Port directions
    logic        ready_pin_function_r, ready_pin_function_nxt;             // Ready pin function
    logic        sync_r, sync_nxt;               // Sync pin enable
    logic [1:0]  flags_r, flags_nxt;             // Channel ready flags
    logic [23:0] test_r, test_nxt;               // Factory test contents
    logic [15:0] sum_r, sum_nxt;                 // Integrity sum contents
    logic [23:0] zero_r, zero_nxt;               // Zero coefficient
    logic [7:0]  mode_r, mode_nxt;               // Mode register
    logic        mchan_r, mchan_nxt;             // Mode channel
    logic        mwr_r, mwr_nxt;                 // Mode write pulse
    logic        soft_r, soft_nxt;               // Soft reset pulse
    logic        dout_r, dout_nxt;               // Serial data out
    logic        rdy_n_r, rdy_n_nxt;             // Ready pin
    logic [7:0]  cmd;                            // Completed command byte
    logic [23:0] rd_val;                         // Value to shift out
    logic [23:0] wr_val;                         // Completed write value
    logic        wr_mode, idle;                  // Mode write now, idle mode
    logic [1:0]  data_rd;                        // Channel data read starts

    // Next-state logic of the whole interface
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        len_nxt   = len_r;
        sh_nxt    = sh_r;
        addr_nxt  = addr_r;
        ones_nxt  = ones_r;
        lvl_nxt   = lvl_r;
        dir_nxt   = dir_r;
        ready_pin_function_nxt = ready_pin_function_r;
        sync_nxt  = sync_r;
        test_nxt  = test_r;
        sum_nxt   = sum_r;
        zero_nxt  = zero_r;
        mode_nxt  = mode_r;
        mchan_nxt = mchan_r;
        mwr_nxt   = 1'b0;
        soft_nxt  = 1'b0;
        dout_nxt  = dout_r;
        wr_mode   = 1'b0;
        data_rd   = 2'b00;
        idle      = mode_r[sra_pkg::MODE_MD_MSB:sra_pkg::MODE_MD_LSB] == sra_pkg::MD_IDLE;
        cmd       = {sh_r[6:0], din_s};
        wr_val    = {sh_r[22:0], din_s};
        rd_val    = '0;
        // Register contents as read, right aligned
        case (cmd[5:0])
            sra_pkg::ADDR_PORT: rd_val[7:0] = {
                dir_r[0] ? port_pin_s[0] : lvl_r[0],
                dir_r[1] ? port_pin_s[1] : lvl_r[1],
                dir_r[0], dir_r[1], ready_pin_function_r, 2'b00, sync_r};
            sra_pkg::ADDR_REV:  rd_val[7:0] = {REV_CODE, GENERIC_CODE};
            sra_pkg::ADDR_TEST: rd_val = test_r;
            sra_pkg::ADDR_STAT: begin
                rd_val[sra_pkg::STAT_CHAN_ZERO_DONE_FLAG_BIT] = flags_r[0];
                rd_val[sra_pkg::STAT_CHAN_ONE_DONE_FLAG_BIT] = flags_r[1];
            end
            sra_pkg::ADDR_SUM:  rd_val[15:0] = sum_r;
            sra_pkg::ADDR_ZERO: rd_val = zero_r;
            sra_pkg::ADDR_DATA0: rd_val = mode_r[sra_pkg::MODE_WIDE_BIT] ? CONV_DATA0
                                          : {8'h00, CONV_DATA0[23:8]};
            sra_pkg::ADDR_DATA1: rd_val = mode_r[sra_pkg::MODE_WIDE_BIT] ? CONV_DATA1
                                          : {8'h00, CONV_DATA1[23:8]};
            sra_pkg::ADDR_MODE0, sra_pkg::ADDR_MODE1: rd_val[7:0] = mode_r;
            default: rd_val = '0;                // Unmapped reads as zero
        endcase
        // Data out changes on the falling serial clock
        if (sclk_fall) begin
            dout_nxt = (state_r == sra_pkg::ST_READ) ? sh_r[23] : 1'b0;
        end
        if (sclk_rise) begin
            ones_nxt = din_s ? ((ones_r == sra_pkg::ONES_RESET) ? ones_r : ones_r + 6'h01)
                             : 6'h00;
            sh_nxt   = {sh_r[22:0], din_s};
            cnt_nxt  = cnt_r + 5'h01;
            case (state_r)
                sra_pkg::ST_CMD: begin
                    if (cnt_r == sra_pkg::LEN_8 - 5'h01) begin
                        addr_nxt = cmd[5:0];
                        len_nxt  = reg_len(cmd[5:0], mode_r[sra_pkg::MODE_WIDE_BIT]);
                        cnt_nxt  = 5'h00;
                        if (cmd[sra_pkg::CMD_RW_BIT]) begin
                            state_nxt = sra_pkg::ST_READ;
                            sh_nxt    = rd_val << (sra_pkg::LEN_24 - len_nxt);
                            data_rd[0] = cmd[5:0] == sra_pkg::ADDR_DATA0;
                            data_rd[1] = cmd[5:0] == sra_pkg::ADDR_DATA1;
                        end else begin
                            state_nxt = sra_pkg::ST_WRITE;
                        end
                    end
                end
                sra_pkg::ST_WRITE: begin
                    if (cnt_r == len_r - 5'h01) begin
                        state_nxt = sra_pkg::ST_CMD;
                        cnt_nxt   = 5'h00;
                        case (addr_r)
                            sra_pkg::ADDR_PORT: begin
                                lvl_nxt   = {wr_val[sra_pkg::PORT_LVL1_BIT],
                                             wr_val[sra_pkg::PORT_LVL0_BIT]};
                                dir_nxt   = {wr_val[sra_pkg::PORT_DIR1_BIT],
                                             wr_val[sra_pkg::PORT_DIR0_BIT]};
                                ready_pin_function_nxt = wr_val[sra_pkg::PORT_READY_PIN_FUNCTION_BIT];
                                sync_nxt  = wr_val[sra_pkg::PORT_SYNC_BIT];
                            end
                            sra_pkg::ADDR_TEST: test_nxt = wr_val;
                            sra_pkg::ADDR_SUM:  sum_nxt  = wr_val[15:0];
                            sra_pkg::ADDR_ZERO: if (idle) zero_nxt = wr_val;
                            sra_pkg::ADDR_MODE0, sra_pkg::ADDR_MODE1: begin
                                mode_nxt  = wr_val[7:0];
                                mchan_nxt = addr_r[sra_pkg::ADDR_CHAN_BIT];
                                mwr_nxt   = 1'b1;
                                wr_mode   = 1'b1;
                            end
                            default: ;                 // Read-only or unmapped
                        endcase
                    end
                end
                sra_pkg::ST_READ: begin
                    if (cnt_r == len_r - 5'h01) begin
                        state_nxt = sra_pkg::ST_CMD;
                        cnt_nxt   = 5'h00;
                    end
                end
                default: begin
                    state_nxt = sra_pkg::ST_CMD;
                    cnt_nxt   = 5'h00;
                end
            endcase
        end
        // Calibration result replaces the coefficient
        if (ZERO_CAL_LOAD) begin
            zero_nxt = ZERO_CAL_VALUE;
        end
        // Long run of ones resets the whole block
        if (ones_nxt == sra_pkg::ONES_RESET && sclk_rise) begin
            state_nxt = sra_pkg::ST_CMD;
            cnt_nxt   = 5'h00;
            len_nxt   = sra_pkg::LEN_8;
            sh_nxt    = '0;
            addr_nxt  = sra_pkg::ADDR_CMD;
            lvl_nxt   = 2'b00;
            dir_nxt   = sra_pkg::DIR_RESET;
            ready_pin_function_nxt = 1'b0;
            sync_nxt  = 1'b0;
            test_nxt  = sra_pkg::TEST_RESET;
            sum_nxt   = sra_pkg::SUM_RESET;
            zero_nxt  = sra_pkg::ZERO_RESET;
            mode_nxt  = sra_pkg::MODE_RESET;
            mchan_nxt = 1'b0;
            mwr_nxt   = 1'b0;
            wr_mode   = 1'b0;
            data_rd   = 2'b00;
            dout_nxt  = 1'b0;
            soft_nxt  = 1'b1;
        end
        // Ready flags: clears first, then sets win
        flags_nxt = flags_r & ~CONV_UPDATE & ~data_rd;
        if (wr_mode || CAL_BUSY || soft_nxt) begin
            flags_nxt = 2'b00;
        end
        flags_nxt = flags_nxt | CONV_DONE;
        if (CAL_DONE) begin
            flags_nxt = 2'b11;
        end
        // Ready pin low on any flag or on all enabled flags
        if (ready_pin_function_nxt) begin
            rdy_n_nxt = !((|CHAN_ENABLE) && (&(flags_nxt | ~CHAN_ENABLE)));
        end else begin
            rdy_n_nxt = !(|flags_nxt);
        end
    end

    // Register the interface state
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_r <= sra_pkg::ST_CMD;
            cnt_r   <= 5'h00;
            len_r   <= sra_pkg::LEN_8;
            sh_r    <= '0;
            addr_r  <= sra_pkg::ADDR_CMD;
            ones_r  <= 6'h00;
            lvl_r   <= 2'b00;
            dir_r   <= sra_pkg::DIR_RESET;
            ready_pin_function_r <= 1'b0;
            sync_r  <= 1'b0;
            flags_r <= 2'b00;
            test_r  <= sra_pkg::TEST_RESET;
            sum_r   <= sra_pkg::SUM_RESET;
            zero_r  <= sra_pkg::ZERO_RESET;
            mode_r  <= sra_pkg::MODE_RESET;
            mchan_r <= 1'b0;
            mwr_r   <= 1'b0;
            soft_r  <= 1'b0;
            dout_r  <= 1'b0;
            rdy_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            len_r   <= len_nxt;
            sh_r    <= sh_nxt;
            addr_r  <= addr_nxt;
            ones_r  <= ones_nxt;
            lvl_r   <= lvl_nxt;
            dir_r   <= dir_nxt;
            ready_pin_function_r <= ready_pin_function_nxt;
            sync_r  <= sync_nxt;
            flags_r <= flags_nxt;
            test_r  <= test_nxt;
            sum_r   <= sum_nxt;
            zero_r  <= zero_nxt;
            mode_r  <= mode_nxt;
            mchan_r <= mchan_nxt;
            mwr_r   <= mwr_nxt;
            soft_r  <= soft_nxt;
            dout_r  <= dout_nxt;
            rdy_n_r <= rdy_n_nxt;
        end
    end

    // Outputs
    assign DOUT               = dout_r;
    assign DOUT_OE_N          = !(cs_low && state_r == sra_pkg::ST_READ);
    assign PORT_PIN_ZERO_OUT  = lvl_r[0];
    assign PORT_PIN_ZERO_OE_N = dir_r[0];
    assign PORT_PIN_ONE_OUT   = lvl_r[1];
    assign PORT_PIN_ONE_OE_N  = dir_r[1];
    assign RDY_N              = rdy_n_r;
    assign SYNC_EN            = sync_r;
    assign ZERO_COEF          = zero_r;
    assign MODE_VALUE         = mode_r;
    assign MODE_CHANNEL       = mchan_r;
    assign MODE_WRITE         = mwr_r;
    assign SOFT_RESET         = soft_r;

    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    chk_phase_return: assert property (
        (state_r != sra_pkg::ST_CMD && sclk_rise && cnt_r == len_r - 5'h01 && !soft_nxt)
        |=> state_r == sra_pkg::ST_CMD && cnt_r == 5'h00)
        else $error("Interface did not return to command phase");
    chk_ones_reset: assert property (
        (sclk_rise && din_s && ones_r == 6'h1f) |=> soft_r && zero_r == sra_pkg::ZERO_RESET)
        else $error("Thirty-two ones did not reset the block");
    chk_pin_enable: assert property (
        (state_r == sra_pkg::ST_WRITE && addr_r == sra_pkg::ADDR_PORT && sclk_rise
         && cnt_r == len_r - 5'h01 && !soft_nxt)
        |=> PORT_PIN_ZERO_OE_N == $past(wr_val[sra_pkg::PORT_DIR0_BIT])
            && PORT_PIN_ONE_OE_N == $past(wr_val[sra_pkg::PORT_DIR1_BIT]))
        else $error("Port pin drive disagrees with direction");
    chk_ready_any: assert property (
        (!ready_pin_function_r && |flags_r) |-> !RDY_N)
        else $error("Ready pin not low with a flag set");
    chk_ready_all: assert property (
        (ready_pin_function_nxt && (&CHAN_ENABLE) && flags_nxt != 2'b11) |=> RDY_N)
        else $error("Ready pin low before all channels ready");
    chk_done_sets: assert property (
        CONV_DONE[0] |=> flags_r[0])
        else $error("Finished conversion did not set flag");
    chk_read_clears: assert property (
        (data_rd[1] && !CONV_DONE[1] && !CAL_DONE) |=> !flags_r[1])
        else $error("Data read did not clear flag");
    chk_mode_clears: assert property (
        (wr_mode && CONV_DONE == 2'b00 && !CAL_DONE) |=> flags_r == 2'b00 ##1 !MODE_WRITE)
        else $error("Mode write did not clear flags");
    chk_cal_flags: assert property (
        (CAL_BUSY && CONV_DONE == 2'b00 && !CAL_DONE) ##1 CAL_DONE |=> flags_r == 2'b11)
        else $error("Calibration flags wrong");
    chk_zero_guard: assert property (
        $changed(zero_r) |-> $past(idle) || $past(ZERO_CAL_LOAD) || soft_r)
        else $error("Zero coefficient changed outside idle");

    cov_read: cover property (state_r == sra_pkg::ST_READ ##1 state_r == sra_pkg::ST_CMD);
    cov_mode_write: cover property (MODE_WRITE && MODE_CHANNEL);
    cov_soft_reset: cover property (SOFT_RESET);
    cov_cal_done: cover property (CAL_DONE ##1 !RDY_N);

endmodule : sra_top

// File: testbench/sra_host_model.sv
// Host model that drives the four-wire serial link
`timescale 1ns/1ps
module sra_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    // Link clock idles high, no frame open
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // One bit: fall, present data, rise, take reply
    task automatic bit_x(input logic b, output logic r);
        sclk = 1'b0;
        din  = b;
        #62.5 sclk = 1'b1;
        r = dout;
        #62.5;
    endtask : bit_x
    // Command byte then n data bits, MSB first
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input int n,
                         output logic [23:0] rd);
        logic r;
        rd   = 24'h00_0000;
        cs_n = 1'b0;
        #61;  // Odd lead-in keeps link edges off the system clock edges
        for (int i = 7; i >= 0; i--) bit_x(cmd[i], r);
        for (int i = n - 1; i >= 0; i--) begin
            bit_x(cmd[6] ? 1'b0 : wd[i], r);
            rd = {rd[22:0], r};
        end
        cs_n = 1'b1;
        din  = ~din;  // Released line shows no stale level
    endtask : frame
    // Interface recovery: 32 ones with select low
    task automatic ones();
        logic r;
        cs_n = 1'b0;
        #61;  // Odd lead-in keeps link edges off the system clock edges
        repeat (32) bit_x(1'b1, r);
        cs_n = 1'b1;
    endtask : ones
endmodule : sra_host_model

// File: testbench/sra_top_tb_top.sv
// Self-checking bench of the serial register access front end
`timescale 1ns/1ps
module sra_top_tb_top;
    logic        clk_sys = 1'b0, nrst = 1'b0, ext0 = 1'b0, ext1 = 1'b0;
    logic        cal_busy = 1'b0, cal_done = 1'b0, zload = 1'b0;
    logic [1:0]  chan_en = 2'b11, upd = 2'b00, done = 2'b00;
    logic [23:0] d0, d1, zval, zw, v;
    wire         sclk, cs_n, din, dout, p0o, p0oe, p1o, p1oe, rdy_n, sync_en, mode_ch;
    wire         dout_oe_n, mode_wr, soft_rst;
    wire  [23:0] zcoef;
    logic [23:0] mw_cnt = 24'h00_0000, sr_cnt = 24'h00_0000;  // Pulse counts
    // Released data line shows the inverse of the last level
    wire dout_line = dout_oe_n ? ~dout : dout;
    wire  [7:0]  mode_v;
    logic [7:0]  port_m;               // Model of the port control byte
    logic [1:0]  flags_m = 2'b00;      // Model of the two ready flags
    int          seed = 5, err_total = 0, n_compared = 0, cycles = 0;
    // Pin levels seen from all drivers
    wire pin0 = p0oe ? ext0 : p0o;
    wire pin1 = p1oe ? ext1 : p1o;
    always #5 clk_sys = ~clk_sys;
    sra_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_line));
    // Count one-cycle pulses away from the launching edge
    always @(negedge clk_sys) begin
        mw_cnt <= mw_cnt + {23'h00_0000, mode_wr};
        sr_cnt <= sr_cnt + {23'h00_0000, soft_rst};
    end
    // Revision codes are arbitrary
    sra_top #(.REV_CODE(4'h5), .GENERIC_CODE(4'hA)) DUT (
        .CLK_SYS(clk_sys), .NRST(nrst), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
        .DOUT(dout), .DOUT_OE_N(dout_oe_n), .PORT_PIN_ZERO_IN(pin0), .PORT_PIN_ZERO_OUT(p0o),
        .PORT_PIN_ZERO_OE_N(p0oe), .PORT_PIN_ONE_IN(pin1), .PORT_PIN_ONE_OUT(p1o),
        .PORT_PIN_ONE_OE_N(p1oe), .RDY_N(rdy_n), .SYNC_EN(sync_en), .CHAN_ENABLE(chan_en),
        .CONV_UPDATE(upd), .CONV_DONE(done), .CONV_DATA0(d0), .CONV_DATA1(d1),
        .CAL_BUSY(cal_busy), .CAL_DONE(cal_done), .ZERO_CAL_LOAD(zload),
        .ZERO_CAL_VALUE(zval), .ZERO_COEF(zcoef), .MODE_VALUE(mode_v),
        .MODE_CHANNEL(mode_ch), .MODE_WRITE(mode_wr), .SOFT_RESET(soft_rst));
    // Compare and count
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    // Register write and read frames
    task automatic wr(input logic [5:0] a, input logic [23:0] wd, input int n);
        logic [23:0] rd;
        @(negedge clk_sys) host.frame({2'b00, a}, wd, n, rd);
        repeat (4) @(negedge clk_sys);
    endtask : wr
    task automatic rdr(input logic [5:0] a, input int n, output logic [23:0] rd);
        @(negedge clk_sys) host.frame({2'b01, a}, 24'h00_0000, n, rd);
        repeat (4) @(negedge clk_sys);
    endtask : rdr
    // Converter event pulses, then ready pin and flag byte against the model
    task automatic pulse(input logic [1:0] u, input logic [1:0] dn, input logic cd);
        logic e;
        upd = u;
        done = dn;
        cal_done = cd;
        @(negedge clk_sys);
        upd = 2'b00;
        done = 2'b00;
        cal_done = 1'b0;
        flags_m = cd ? 2'b11 : (flags_m & ~u) | dn;
        e = port_m[3] ? (chan_en == 2'b00 || (flags_m & chan_en) != chan_en) : flags_m == 0;
        @(negedge clk_sys);
        check(rdy_n, e);
        rdr(sra_pkg::ADDR_STAT, 8, v);
        check(v, {flags_m[1], 1'b0, flags_m[0]});
    endtask : pulse
    // Verdict and end of run
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        d0 = 24'($random(seed));
        d1 = 24'($random(seed));
        zval = 24'($random(seed));
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        check({p0oe, p1oe, rdy_n, sync_en}, 4'b1110);
        rdr(sra_pkg::ADDR_ZERO, 24, v); check(v, 24'h80_0000);
        rdr(sra_pkg::ADDR_REV, 8, v); check(v, 24'h00_005A);
        rdr(sra_pkg::ADDR_TEST, 24, v); check(v, 24'h00_0000);
        // Random port settings, pins driven or read back
        for (int k = 0; k < 4; k++) begin
            port_m = 8'($random(seed)) & 8'hF9;
            wr(sra_pkg::ADDR_PORT, port_m, 8);
            {ext1, ext0} = 2'($random(seed));
            repeat (4) @(negedge clk_sys);
            zw = {port_m[5] ? ext0 : port_m[7], port_m[4] ? ext1 : port_m[6], port_m[5:0]};
            check({pin0, pin1, p0oe, p1oe, sync_en}, {zw[7:4], zw[0]});
            rdr(sra_pkg::ADDR_PORT, 8, v); check(v, zw);
        end
        // Ready flags, any-channel then all-enabled function
        port_m = 8'h30;
        wr(sra_pkg::ADDR_PORT, port_m, 8);
        pulse(2'b00, 2'b01, 1'b0);
        rdr(sra_pkg::ADDR_DATA0, 16, v); check(v, d0[23:8]);
        flags_m = 2'b00;
        pulse(2'b00, 2'b00, 1'b0);
        port_m = 8'h38;
        wr(sra_pkg::ADDR_PORT, port_m, 8);
        pulse(2'b00, 2'b10, 1'b0);
        pulse(2'b00, 2'b01, 1'b0);
        pulse(2'b10, 2'b00, 1'b0);
        // Mode write on channel one, wide results
        wr(sra_pkg::ADDR_MODE1, 24'h00_0002, 8);
        check({mode_ch, mode_v}, 9'h102);
        check(mw_cnt, 24'h00_0001);
        flags_m = 2'b00;
        pulse(2'b00, 2'b00, 1'b0);
        rdr(sra_pkg::ADDR_DATA1, 24, v); check(v, d1);
        rdr(sra_pkg::ADDR_MODE0, 8, v); check(v, 24'h00_0002);
        // Calibration holds flags low, then sets both
        pulse(2'b00, 2'b11, 1'b0);
        cal_busy = 1'b1;
        flags_m = 2'b00;
        pulse(2'b00, 2'b00, 1'b0);
        cal_busy = 1'b0;
        pulse(2'b00, 2'b00, 1'b1);
        // Zero coefficient: idle write, refused write, auto load
        zw = 24'($random(seed));
        wr(sra_pkg::ADDR_SUM, zw, 16);
        rdr(sra_pkg::ADDR_SUM, 16, v); check(v, zw[15:0]);
        wr(sra_pkg::ADDR_ZERO, zw, 24);
        check(zcoef, zw);
        wr(sra_pkg::ADDR_MODE0, 24'h00_0020, 8);
        wr(sra_pkg::ADDR_ZERO, ~zw, 24);
        rdr(sra_pkg::ADDR_ZERO, 24, v); check(v, zw);
        zload = 1'b1;
        @(negedge clk_sys) zload = 1'b0;
        @(negedge clk_sys) check(zcoef, zval);
        // Interface recovery restores defaults
        @(negedge clk_sys) host.ones();
        repeat (8) @(negedge clk_sys);
        check({p0oe, p1oe, rdy_n, sync_en, mode_v}, 12'hE00);
        check(sr_cnt, 24'h00_0001);
        rdr(sra_pkg::ADDR_ZERO, 24, v); check(v, 24'h80_0000);
        print_verdict();
    end
endmodule : sra_top_tb_top
